//--- rtl/spp_pkg.sv
// shared constants and types of the serial port pin and select logic
package spp_pkg;
	// ------------------------------------------------------------
	// sizes, counts and select codes
	// ------------------------------------------------------------
	localparam int SPP_BITS = 8;
	localparam int SPP_FIFO_DEPTH = 4;
	localparam int SPP_HALF_DEF = 4;
	localparam logic [1:0] SPP_SEL_3WIRE = 2'h0;
	localparam logic [1:0] SPP_SEL_4IN = 2'h1;
	localparam logic [2:0] SPP_CNT_RST = 3'h0;
	localparam logic [2:0] SPP_CNT_LAST = 3'h7;
	localparam logic [7:0] SPP_SHIFT_RST = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic port_enable_bit;
		logic master_enable_bit;
		logic [1:0] select_mode_field;
	} spp_cfg_t;

	typedef struct packed {
		logic mosi_out;
		logic mosi_oe_n;
		logic miso_out;
		logic miso_oe_n;
		logic sck_out;
		logic sck_oe_n;
		logic nss_out;
		logic nss_oe_n;
		logic nss_mapped;
	} spp_pins_t;

	typedef enum {SPP_IDLE, SPP_LOW, SPP_HIGH} spp_state_t;

	localparam spp_cfg_t SPP_CFG_RST = '{1'b0, 1'b0, 2'h1};
	localparam spp_pins_t SPP_PINS_RST = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : spp_pkg

//--- rtl/spp_port.sv
// serial port zero: transmit fifo, pin drive and select mode handling
`timescale 1ns/1ps

// ------------------------------------------------------------
// transmit fifo
// ------------------------------------------------------------
module spp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	logic push, pop;

	always_comb begin
		push = in_valid && ready_q;
		pop = out_ready && (cnt_q != '0);
		wr_d = wr_q;
		rd_d = rd_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		// full is registered so the fill side sees honest back-pressure
		ready_d = (cnt_d != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	assign in_ready = ready_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
endmodule : spp_fifo

// ------------------------------------------------------------
// port core
// ------------------------------------------------------------
// How it works
// - master or slave, three or four wire, full duplex, multi-party bus.
// - master-to-slave line is output as master, input as slave.
// - master drives that line from shift register msb, msb first.
// - slave-to-master line is input as master, output as slave, msb first.
// - slave-to-master output floats when disabled or unselected four-wire slave.
// - three-wire slave always drives slave-to-master line from shift msb.
// - serial clock is driven only as master; slaves take it from outside.
// - four-wire slave ignores serial clock while select input is high.
// - select mode 00 is three-wire, pin unused, slave always selected.
// - select mode 01 is four-wire with select pin as input.
// - mode 01 master: select falling edge disables the master function.
// - select mode 1x drives select pin with the low mode bit.
// - select is routed to a pin except in three-wire operation.
// - select fault clears master and port enables and sets mode fault.
// - four-wire slave resets bit counter on select falling edge.
// - slave sets transfer complete and stores byte after eight bits.
module spp_port #(
	parameter int HALF_CYC = spp_pkg::SPP_HALF_DEF,
	parameter int FIFO_DEPTH = spp_pkg::SPP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// configuration
	input wire logic cfg_wr,
	input wire spp_pkg::spp_cfg_t cfg_in,
	output spp_pkg::spp_cfg_t cfg_out,
	input wire logic mode_fault_clr,
	output logic mode_fault_flag,
	input wire logic transfer_complete_clr,
	output logic transfer_complete_flag,
	// transmit stream
	input wire logic tx_valid,
	input wire logic [spp_pkg::SPP_BITS-1:0] tx_data,
	output logic tx_ready,
	// receive byte
	output logic rx_valid,
	output logic [spp_pkg::SPP_BITS-1:0] rx_data,
	// pins
	input wire logic mosi_in,
	input wire logic miso_in,
	input wire logic sck_in,
	input wire logic nss_in,
	output spp_pkg::spp_pins_t pins
);
	import spp_pkg::*;

	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sck_m_q, sck_s_q, sck_p_q;
	logic mosi_m_q, mosi_s_q, miso_m_q, miso_s_q;
	logic nss_m_q, nss_s_q, nss_p_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			mosi_m_q <= 1'b0;
			mosi_s_q <= 1'b0;
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
			nss_m_q <= 1'b1;
			nss_s_q <= 1'b1;
			nss_p_q <= 1'b1;
		end else begin
			sck_m_q <= sck_in;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			mosi_m_q <= mosi_in;
			mosi_s_q <= mosi_m_q;
			miso_m_q <= miso_in;
			miso_s_q <= miso_m_q;
			nss_m_q <= nss_in;
			nss_s_q <= nss_m_q;
			nss_p_q <= nss_s_q;
		end
	end

	// ------------------------------------------------------------
	// transmit fifo
	// ------------------------------------------------------------
	logic f_valid, f_pop;
	logic [SPP_BITS-1:0] f_data;

	spp_fifo #(.WIDTH(SPP_BITS), .DEPTH(FIFO_DEPTH)) u_spp_fifo (
		.clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(tx_valid),
		.in_data(tx_data),
		.in_ready(tx_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_pop)
	);

	// ------------------------------------------------------------
	// core state
	// ------------------------------------------------------------
	spp_cfg_t cfg_q, cfg_d;
	spp_pins_t pins_q, pins_d;
	spp_state_t st_q, st_d;
	logic fault_q, fault_d, done_q, done_d, rxv_q, rxv_d;
	logic samp_q, samp_d, pend_q, pend_d, full_q, full_d;
	logic [7:0] sh_q, sh_d, rx_q, rx_d, div_q, div_d;
	logic [2:0] cnt_q, cnt_d;
	logic is_m, is_s, sel, sck_rise, sck_fall, nss_fall, four_in;

	always_comb begin
		is_m = cfg_q.port_enable_bit && cfg_q.master_enable_bit;
		is_s = cfg_q.port_enable_bit && !cfg_q.master_enable_bit;
		four_in = (cfg_q.select_mode_field == SPP_SEL_4IN);
		sel = (cfg_q.select_mode_field == SPP_SEL_3WIRE) || !nss_s_q;
		sck_rise = sck_s_q && !sck_p_q;
		sck_fall = !sck_s_q && sck_p_q;
		nss_fall = !nss_s_q && nss_p_q;
		cfg_d = cfg_q;
		st_d = st_q;
		fault_d = fault_q;
		done_d = done_q;
		rxv_d = 1'b0;
		samp_d = samp_q;
		pend_d = pend_q;
		full_d = full_q;
		sh_d = sh_q;
		rx_d = rx_q;
		div_d = div_q;
		cnt_d = cnt_q;
		f_pop = 1'b0;
		if (mode_fault_clr) begin
			fault_d = 1'b0;
		end
		if (transfer_complete_clr) begin
			done_d = 1'b0;
		end
		if (cfg_wr) begin
			cfg_d = cfg_in;
			if (!cfg_in.port_enable_bit) begin
				// disabling is the only way to realign a three-wire slave
				cnt_d = SPP_CNT_RST;
				pend_d = 1'b0;
				st_d = SPP_IDLE;
			end
		end
		if (is_m) begin
			if (four_in && nss_fall) begin
				cfg_d.port_enable_bit = 1'b0;
				cfg_d.master_enable_bit = 1'b0;
				fault_d = 1'b1;
				st_d = SPP_IDLE;
			end else begin
				case (st_q)
					SPP_IDLE: begin
						if (f_valid) begin
							sh_d = f_data;
							f_pop = 1'b1;
							cnt_d = SPP_CNT_RST;
							div_d = 8'h00;
							st_d = SPP_LOW;
						end
					end
					SPP_LOW: begin
						div_d = div_q + 8'h01;
						if (div_q == HALF_LAST) begin
							div_d = 8'h00;
							st_d = SPP_HIGH;
						end
					end
					SPP_HIGH: begin
						div_d = div_q + 8'h01;
						if (div_q == HALF_LAST) begin
							div_d = 8'h00;
							if (cnt_q == SPP_CNT_LAST) begin
								// sample at the end of the high half: the synchroniser lag
								// would otherwise read the bit before the peer shifted it
								rx_d = {sh_q[6:0], miso_s_q};
								rxv_d = 1'b1;
								done_d = 1'b1;
								cnt_d = SPP_CNT_RST;
								st_d = SPP_IDLE;
							end else begin
								sh_d = {sh_q[6:0], miso_s_q};
								cnt_d = cnt_q + 3'h1;
								st_d = SPP_LOW;
							end
						end
					end
					default: st_d = SPP_IDLE;
				endcase
			end
		end else if (is_s) begin
			if (!full_q && f_valid && cnt_q == SPP_CNT_RST && !pend_q) begin
				sh_d = f_data;
				f_pop = 1'b1;
				full_d = 1'b1;
			end
			if (four_in && nss_fall) begin
				cnt_d = SPP_CNT_RST;
				pend_d = 1'b0;
			end else if (sel && sck_rise) begin
				if (cnt_q == SPP_CNT_LAST) begin
					rx_d = {sh_q[6:0], mosi_s_q};
					rxv_d = 1'b1;
					done_d = 1'b1;
					cnt_d = SPP_CNT_RST;
					pend_d = 1'b0;
					f_pop = f_valid;
					full_d = f_valid;
					sh_d = f_valid ? f_data : sh_q;
				end else begin
					samp_d = mosi_s_q;
					cnt_d = cnt_q + 3'h1;
					pend_d = 1'b1;
				end
			end else if (sel && sck_fall && pend_q) begin
				sh_d = {sh_q[6:0], samp_q};
				pend_d = 1'b0;
			end
		end
		if (!is_m) st_d = SPP_IDLE;
		pins_d.mosi_out = sh_q[7];
		pins_d.mosi_oe_n = !is_m;
		pins_d.miso_out = sh_q[7];
		pins_d.miso_oe_n = !(is_s && sel);
		pins_d.sck_out = (st_q == SPP_HIGH);
		pins_d.sck_oe_n = !is_m;
		pins_d.nss_out = cfg_q.select_mode_field[0];
		pins_d.nss_oe_n = !cfg_q.select_mode_field[1];
		pins_d.nss_mapped = (cfg_q.select_mode_field != SPP_SEL_3WIRE);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= SPP_CFG_RST;
			pins_q <= SPP_PINS_RST;
			st_q <= SPP_IDLE;
			fault_q <= 1'b0;
			done_q <= 1'b0;
			rxv_q <= 1'b0;
			samp_q <= 1'b0;
			pend_q <= 1'b0;
			full_q <= 1'b0;
			sh_q <= SPP_SHIFT_RST;
			rx_q <= SPP_SHIFT_RST;
			div_q <= 8'h00;
			cnt_q <= SPP_CNT_RST;
		end else begin
			cfg_q <= cfg_d;
			pins_q <= pins_d;
			st_q <= st_d;
			fault_q <= fault_d;
			done_q <= done_d;
			rxv_q <= rxv_d;
			samp_q <= samp_d;
			pend_q <= pend_d;
			full_q <= full_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			div_q <= div_d;
			cnt_q <= cnt_d;
		end
	end

	assign cfg_out = cfg_q;
	assign mode_fault_flag = fault_q;
	assign transfer_complete_flag = done_q;
	assign rx_valid = rxv_q;
	assign rx_data = rx_q;
	assign pins = pins_q;
endmodule : spp_port

//--- test/spp_checker.sv
// concurrent checks on the pin drive and select handling of the serial port
`timescale 1ns/1ps
module spp_checker
	import spp_pkg::*;
(
	// watched top ports
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire spp_pkg::spp_cfg_t cfg_out,
	input wire logic mode_fault_clr,
	input wire logic mode_fault_flag,
	input wire logic rx_valid,
	input wire logic transfer_complete_flag,
	input wire logic nss_in,
	input wire spp_pkg::spp_pins_t pins
);
	// ------------------------------------------------------------
	// pins lag config by one cycle, so config must be steady first
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_master;
		$stable(cfg_out) && cfg_out.port_enable_bit && cfg_out.master_enable_bit;
	endsequence
	sequence s_slave;
		$stable(cfg_out) && cfg_out.port_enable_bit && !cfg_out.master_enable_bit;
	endsequence
	a_master_drive: assert property (s_master |-> !pins.mosi_oe_n && !pins.sck_oe_n && pins.miso_oe_n)
		else $error("master pin drive wrong");
	a_slave_listen: assert property (s_slave |-> pins.mosi_oe_n && pins.sck_oe_n)
		else $error("slave drives master lines");
	a_miso_off: assert property ($stable(cfg_out) && !cfg_out.port_enable_bit |-> pins.miso_oe_n)
		else $error("miso driven while disabled");
	a_unsel_float: assert property (nss_in [*6] ##0 s_slave ##0 cfg_out.select_mode_field == SPP_SEL_4IN |-> pins.miso_oe_n)
		else $error("miso driven while unselected");
	a_slave3_drive: assert property (s_slave ##0 cfg_out.select_mode_field == SPP_SEL_3WIRE |-> !pins.miso_oe_n)
		else $error("three wire slave not driving miso");
	a_sel_out: assert property ($stable(cfg_out) && cfg_out.port_enable_bit && cfg_out.select_mode_field[1] |-> !pins.nss_oe_n && pins.nss_out == cfg_out.select_mode_field[0])
		else $error("select output level wrong");
	a_sel_mapped: assert property ($stable(cfg_out) |-> pins.nss_mapped == (cfg_out.select_mode_field != SPP_SEL_3WIRE))
		else $error("select routing wrong");
	a_fault_clear: assert property ($rose(mode_fault_flag) |-> ##[0:1] !cfg_out.port_enable_bit && !cfg_out.master_enable_bit)
		else $error("fault left port enabled");
	a_fault_sticky: assert property ($fell(mode_fault_flag) |-> $past(mode_fault_clr))
		else $error("fault flag dropped by itself");
	a_done_flag: assert property (rx_valid |-> ##[0:1] transfer_complete_flag)
		else $error("byte end without done flag");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("byte strobe longer than one cycle");
endmodule : spp_checker

bind spp_port spp_checker u_spp_checker (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_out(cfg_out),
	.mode_fault_clr(mode_fault_clr), .mode_fault_flag(mode_fault_flag), .rx_valid(rx_valid),
	.transfer_complete_flag(transfer_complete_flag), .nss_in(nss_in), .pins(pins));

//--- test/spp_peer.sv
// far-side serial peer: answering slave or clock-driving master
`timescale 1ns/1ps
module spp_peer (
	// resolved bus lines
	input wire logic sck_w,
	input wire logic mosi_w,
	input wire logic miso_w,
	// lines the peer drives
	output logic sck_o,
	output logic mosi_o,
	output logic miso_o,
	output logic nss_o
);
	logic [7:0] sh;
	logic [7:0] got;
	int cnt;
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		nss_o = 1'b1;
		sh = 8'hA5;
		got = 8'h00;
		cnt = 0;
	end
	// sole slave on the bus, no select needed
	assign miso_o = sh[7];
	always @(posedge sck_w) begin
		got = {got[6:0], mosi_w};
		cnt = cnt + 1;
	end
	// next answer is the inverse of the byte just heard
	always @(negedge sck_w) begin
		sh = (cnt == 8) ? ~got : {sh[6:0], 1'b0};
		if (cnt == 8) cnt = 0;
	end
	task automatic xfer(input logic [7:0] b, input logic sel, output logic [7:0] r);
		nss_o = !sel;
		#160;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = b[i];
			#160 sck_o = 1'b1;
			#159 r[i] = miso_w;
			#1 sck_o = 1'b0;
		end
		#160 nss_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask : xfer
endmodule : spp_peer

//--- test/spp_port_tb.sv
// self-checking bench of the serial port pin and select logic
`timescale 1ns/1ps
module spp_port_tb;
	import spp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_wr = 1'b0;
	spp_cfg_t cfg_in = SPP_CFG_RST;
	logic mode_fault_clr = 1'b0;
	logic done_clr = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	spp_cfg_t cfg_out;
	spp_pins_t pins;
	logic mode_fault_flag, transfer_complete_flag, tx_ready, rx_valid;
	logic [7:0] rx_data, r, b, prev;
	logic mosi_w, miso_w, sck_w, nss_w, pm_sck, pm_mosi, pm_miso, pm_nss;
	logic [7:0] q[$];
	logic [7:0] tb_tx[4];
	int fail_count = 0;
	int n_compared = 0;
	initial forever #20 sys_clk = ~sys_clk;
	// ------------------------------------------------------------
	// wire resolution and instances
	// ------------------------------------------------------------
	assign mosi_w = !pins.mosi_oe_n ? pins.mosi_out : pm_mosi;
	assign miso_w = !pins.miso_oe_n ? pins.miso_out : pm_miso;
	assign sck_w = !pins.sck_oe_n ? pins.sck_out : pm_sck;
	assign nss_w = !pins.nss_oe_n ? pins.nss_out : pm_nss;
	spp_port #(.HALF_CYC(2), .FIFO_DEPTH(SPP_FIFO_DEPTH)) u_spp_port (.sys_clk(sys_clk),
		.rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_out(cfg_out),
		.mode_fault_clr(mode_fault_clr), .mode_fault_flag(mode_fault_flag),
		.transfer_complete_clr(done_clr), .transfer_complete_flag(transfer_complete_flag),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .mosi_in(mosi_w), .miso_in(miso_w), .sck_in(sck_w),
		.nss_in(nss_w), .pins(pins));
	spp_peer u_spp_peer (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .sck_o(pm_sck),
		.mosi_o(pm_mosi), .miso_o(pm_miso), .nss_o(pm_nss));
	task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic set_cfg(input spp_cfg_t c);
		cfg_in = c;
		cfg_wr = 1'b1;
		cyc(1);
		cfg_wr = 1'b0;
		cyc(3);
	endtask : set_cfg
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	always @(posedge sys_clk) begin
		#2;
		if (rx_valid === 1'b1) begin
			if (q.size() == 0) chk("rx_extra", 9'h001, 9'h000);
			else chk("rx_data", rx_data, q.pop_front());
		end
	end
	initial begin
		#100000;
		fail_count++;
		close_out();
	end
	initial begin
		void'($urandom(27946));
		cyc(3);
		rst_n = 1'b1;
		chk("cfg_rst", cfg_out, SPP_CFG_RST);
		chk("pins_rst", pins, SPP_PINS_RST);
		prev = 8'hA5;
		for (int i = 0; i < 4; i++) begin
			tb_tx[i] = 8'($urandom);
			chk("tx_ready", tx_ready, 9'h001);
			tx_data = tb_tx[i];
			tx_valid = 1'b1;
			q.push_back(prev);
			prev = ~tb_tx[i];
			cyc(1);
		end
		tx_valid = 1'b0;
		cyc(1);
		chk("tx_full", tx_ready, 9'h000);
		set_cfg(spp_cfg_t'(4'hC));
		for (int i = 0; i < 400 && q.size() > 0; i++) cyc(1);
		chk("peer_got", u_spp_peer.got, tb_tx[3]);
		chk("done_m", transfer_complete_flag, 9'h001);
		done_clr = 1'b1;
		cyc(1);
		done_clr = 1'b0;
		chk("done_clr", transfer_complete_flag, 9'h000);
		$display("test master drain done");
		set_cfg(spp_cfg_t'(4'h9));
		tb_tx[0] = 8'($urandom);
		tx_data = tb_tx[0];
		tx_valid = 1'b1;
		cyc(1);
		tx_valid = 1'b0;
		u_spp_peer.xfer(8'h3C, 1'b0, r);
		chk("done_unsel", transfer_complete_flag, 9'h000);
		b = 8'($urandom);
		q.push_back(b);
		u_spp_peer.xfer(b, 1'b1, r);
		cyc(8);
		chk("slave_miso", r, tb_tx[0]);
		chk("rx_left", 9'(q.size()), 9'h000);
		chk("done_s", transfer_complete_flag, 9'h001);
		set_cfg(spp_cfg_t'(4'h8));
		b = 8'($urandom);
		q.push_back(b);
		u_spp_peer.xfer(b, 1'b0, r);
		cyc(8);
		chk("rx_left", 9'(q.size()), 9'h000);
		$display("test slave frames done");
		set_cfg(spp_cfg_t'(4'hD));
		u_spp_peer.nss_o = 1'b0;
		cyc(6);
		chk("fault", mode_fault_flag, 9'h001);
		chk("fault_cfg", cfg_out, 9'h001);
		mode_fault_clr = 1'b1;
		cyc(1);
		mode_fault_clr = 1'b0;
		u_spp_peer.nss_o = 1'b1;
		cyc(2);
		chk("fault_clr", mode_fault_flag, 9'h000);
		$display("test mode fault done");
		for (int m = 2; m < 4; m++) begin
			set_cfg(spp_cfg_t'({2'h3, 2'(m)}));
			chk("nss_out", 9'(pins.nss_out), 9'(m & 1));
		end
		set_cfg(spp_cfg_t'(4'h1));
		$display("test select output done");
		close_out();
	end
endmodule : spp_port_tb
